// File: src/timer_a_capture_control.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - in capture mode a selected pin edge copies the count into the data register
// - software picks rising or falling capture edge
// - port 3 high bits 5:4 of 00/01 make pin input, 10/11 output
// - capture mode raises the overflow interrupt on each counter overflow
// - capture mode raises match/capture interrupt on each capture load
// - control register selects interval, capture or pwm mode and count clock
// - reset clears control to 00: interval, divide by 1024, interrupts off
// - writing 1 to control bit 3 clears the counter at any time
// - writing 1 to control bit 0 starts the counter
// - overflow pending stays set until software clears it
// - match/capture interrupt requests service only while control bit 1 is set
// - writing 0 to a pending bit clears it; software does so in service routine
// - the control register can also clear the match/capture pending condition
// - control register sits at F3 and is readable and writable
// - a second 8-bit counter gives interval interrupts and a carrier output
// - count clock is master clock over 1024, 256, 64 or external pin
// - interval mode match toggles output, raises match interrupt, clears counter
// - pwm match keeps counting, wraps FF to 00; output high while data > count
module timer_a_capture_control #(
   parameter int DATA_W = timer_a_pkg::DATA_W,
   parameter int PRE_W  = timer_a_pkg::PRE_W
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic [7:0]        reg_addr,
   input  wire logic              reg_wr,
   input  wire logic [7:0]        reg_wdata,
   output logic      [7:0]        reg_rdata,
   input  wire logic              capture_input_pin,
   input  wire logic              timer_a_external_clock_pin,
   output logic                   timer_a_output_pin_out,
   output logic                   timer_a_output_pin_oe,
   output logic                   timer_a_overflow_irq,
   output logic                   timer_a_match_capture_irq,
   output logic                   timer_b_irq,
   output logic                   timer_b_carrier_out
);
   localparam int PND_W_L = timer_a_pkg::PND_W;

   logic [7:0]        ta_control_reg, ta_control_next, tb_control_reg, tb_control_next;
   logic [7:0]        port3_high_reg, port3_high_next, cap_config_reg, cap_config_next;
   logic [DATA_W-1:0] ta_data_reg, ta_data_next, ta_count_reg, ta_count_next;
   logic [DATA_W-1:0] tb_data_reg, tb_data_next, tb_count_reg, tb_count_next;
   logic [PND_W_L-1:0] pend_reg, pend_next;
   logic [PRE_W-1:0]  pre_reg, pre_next;
   logic [2:0]        cap_sync_reg, cap_sync_next, ext_sync_reg, ext_sync_next;
   logic              ta_out_next, tb_out_next, ovf_irq_next, mc_irq_next, tb_irq_next;
   logic [7:0]        rdata_next;
   logic [1:0]        ta_mode;
   logic              ext_rise, cap_rise, cap_fall, capture_evt;
   logic              ta_tick, ta_match, ta_ovf, ta_clr_wr, tb_tick, tb_match;

   // shared prescaler keeps both timers phase-aligned to one divider chain
   function automatic logic div_tick(input logic [PRE_W-1:0] pre, input logic [1:0] sel,
                                     input logic ext);
      case (sel)
         timer_a_pkg::CLK_DIV1024: div_tick = (pre & timer_a_pkg::MASK_DIV1024)
                                              == timer_a_pkg::MASK_DIV1024;
         timer_a_pkg::CLK_DIV256:  div_tick = (pre & timer_a_pkg::MASK_DIV256)
                                              == timer_a_pkg::MASK_DIV256;
         timer_a_pkg::CLK_DIV64:   div_tick = (pre & timer_a_pkg::MASK_DIV64)
                                              == timer_a_pkg::MASK_DIV64;
         default:                  div_tick = ext;
      endcase
   endfunction

   function automatic logic wr_hit(input logic [7:0] a);
      wr_hit = reg_wr && (reg_addr == a);
   endfunction

   always_comb
   begin
      // stage 0 feeds stage 1 only; edges look at stages 1 and 2
      cap_sync_next = {cap_sync_reg[1:0], capture_input_pin};
      ext_sync_next = {ext_sync_reg[1:0], timer_a_external_clock_pin};
      ext_rise = ext_sync_reg[1] && !ext_sync_reg[2];
      cap_rise = cap_sync_reg[1] && !cap_sync_reg[2];
      cap_fall = !cap_sync_reg[1] && cap_sync_reg[2];
      pre_next = pre_reg + PRE_W'(1);
      ta_mode  = ta_control_reg[timer_a_pkg::TA_MODE_LSB +: 2];
      ta_tick  = ta_control_reg[timer_a_pkg::TA_START_BIT]
                 && div_tick(pre_reg, ta_control_reg[timer_a_pkg::TA_CLK_LSB +: 2],
                             ext_rise);
      capture_evt = (ta_mode == timer_a_pkg::MODE_CAPTURE)
                    && !port3_high_reg[timer_a_pkg::P3H_OUT_BIT]
                    && (cap_config_reg[timer_a_pkg::CAP_RISING_BIT] ? cap_rise
                                                                    : cap_fall);
      ta_match = ta_tick && (ta_mode != timer_a_pkg::MODE_CAPTURE)
                 && (ta_count_reg == ta_data_reg);
      ta_ovf   = ta_tick && (ta_count_reg == timer_a_pkg::COUNT_MAX)
                 && !(ta_match && (ta_mode == timer_a_pkg::MODE_INTERVAL));
      ta_clr_wr = wr_hit(timer_a_pkg::ADDR_TA_CONTROL)
                  && reg_wdata[timer_a_pkg::TA_CLR_BIT];

      ta_control_next = ta_control_reg;
      if (wr_hit(timer_a_pkg::ADDR_TA_CONTROL))
      begin
         ta_control_next = reg_wdata;
         // clear is a strobe, never stored
         ta_control_next[timer_a_pkg::TA_CLR_BIT] = 1'b0;
      end
      port3_high_next = wr_hit(timer_a_pkg::ADDR_PORT3_HIGH) ? reg_wdata : port3_high_reg;
      cap_config_next = wr_hit(timer_a_pkg::ADDR_CAP_CONFIG) ? reg_wdata : cap_config_reg;

      ta_count_next = ta_count_reg;
      if (ta_clr_wr)
         ta_count_next = timer_a_pkg::COUNT_ZERO;
      else if (ta_match && (ta_mode == timer_a_pkg::MODE_INTERVAL))
         ta_count_next = timer_a_pkg::COUNT_ZERO;
      else if (ta_tick)
         ta_count_next = ta_count_reg + DATA_W'(1);

      // a capture outranks a cpu write landing in the same cycle
      ta_data_next = ta_data_reg;
      if (capture_evt)
         ta_data_next = ta_count_reg;
      else if (wr_hit(timer_a_pkg::ADDR_TA_DATA))
         ta_data_next = reg_wdata;

      ta_out_next = timer_a_output_pin_out;
      if (ta_mode == timer_a_pkg::MODE_PWM)
         ta_out_next = ta_data_reg > ta_count_reg;
      else if (ta_match && (ta_mode == timer_a_pkg::MODE_INTERVAL))
         ta_out_next = !timer_a_output_pin_out;

      tb_control_next = tb_control_reg;
      if (wr_hit(timer_a_pkg::ADDR_TB_CONTROL))
      begin
         tb_control_next = reg_wdata;
         tb_control_next[timer_a_pkg::TB_CLR_BIT] = 1'b0;
      end
      tb_data_next = wr_hit(timer_a_pkg::ADDR_TB_DATA) ? reg_wdata : tb_data_reg;
      tb_tick  = tb_control_reg[timer_a_pkg::TB_START_BIT]
                 && div_tick(pre_reg, tb_control_reg[timer_a_pkg::TB_CLK_LSB +: 2], ext_rise);
      tb_match = tb_tick && (tb_count_reg == tb_data_reg);
      tb_count_next = tb_count_reg;
      if (wr_hit(timer_a_pkg::ADDR_TB_CONTROL) && reg_wdata[timer_a_pkg::TB_CLR_BIT])
         tb_count_next = timer_a_pkg::COUNT_ZERO;
      else if (tb_match)
         tb_count_next = timer_a_pkg::COUNT_ZERO;
      else if (tb_tick)
         tb_count_next = tb_count_reg + DATA_W'(1);
      tb_out_next = tb_match ? !timer_b_carrier_out : timer_b_carrier_out;

      // clears first, sets last: an event in the clearing cycle survives
      pend_next = pend_reg;
      if (wr_hit(timer_a_pkg::ADDR_PENDING))
         pend_next = pend_reg & reg_wdata[PND_W_L-1:0];
      if (ta_clr_wr)
         pend_next[timer_a_pkg::PND_MC_BIT] = 1'b0;
      if (capture_evt || ta_match)
         pend_next[timer_a_pkg::PND_MC_BIT] = 1'b1;
      if (ta_ovf)
         pend_next[timer_a_pkg::PND_OVF_BIT] = 1'b1;
      if (tb_match)
         pend_next[timer_a_pkg::PND_TB_BIT] = 1'b1;

      ovf_irq_next = pend_reg[timer_a_pkg::PND_OVF_BIT]
                     && ta_control_reg[timer_a_pkg::TA_OVF_IE_BIT];
      mc_irq_next  = pend_reg[timer_a_pkg::PND_MC_BIT]
                     && ta_control_reg[timer_a_pkg::TA_MC_IE_BIT];
      tb_irq_next  = pend_reg[timer_a_pkg::PND_TB_BIT]
                     && tb_control_reg[timer_a_pkg::TB_IE_BIT];

      case (reg_addr)
         timer_a_pkg::ADDR_PORT3_HIGH: rdata_next = port3_high_reg;
         timer_a_pkg::ADDR_TA_CONTROL: rdata_next = ta_control_reg;
         timer_a_pkg::ADDR_TA_DATA:    rdata_next = ta_data_reg;
         timer_a_pkg::ADDR_TA_COUNT:   rdata_next = ta_count_reg;
         timer_a_pkg::ADDR_PENDING:    rdata_next = {{(8-PND_W_L){1'b0}}, pend_reg};
         timer_a_pkg::ADDR_TB_CONTROL: rdata_next = tb_control_reg;
         timer_a_pkg::ADDR_TB_DATA:    rdata_next = tb_data_reg;
         timer_a_pkg::ADDR_TB_COUNT:   rdata_next = tb_count_reg;
         timer_a_pkg::ADDR_CAP_CONFIG: rdata_next = cap_config_reg;
         default:                      rdata_next = timer_a_pkg::RESET_VALUE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ta_control_reg            <= timer_a_pkg::RESET_VALUE;
         tb_control_reg            <= timer_a_pkg::RESET_VALUE;
         port3_high_reg            <= timer_a_pkg::RESET_VALUE;
         cap_config_reg            <= timer_a_pkg::RESET_VALUE;
         ta_data_reg               <= '0;
         ta_count_reg              <= '0;
         tb_data_reg               <= '0;
         tb_count_reg              <= '0;
         pend_reg                  <= '0;
         pre_reg                   <= '0;
         cap_sync_reg              <= '0;
         ext_sync_reg              <= '0;
         timer_a_output_pin_out    <= 1'b0;
         timer_a_output_pin_oe     <= 1'b0;
         timer_a_overflow_irq      <= 1'b0;
         timer_a_match_capture_irq <= 1'b0;
         timer_b_irq               <= 1'b0;
         timer_b_carrier_out       <= 1'b0;
         reg_rdata                 <= timer_a_pkg::RESET_VALUE;
      end
      else
      begin
         ta_control_reg            <= ta_control_next;
         tb_control_reg            <= tb_control_next;
         port3_high_reg            <= port3_high_next;
         cap_config_reg            <= cap_config_next;
         ta_data_reg               <= ta_data_next;
         ta_count_reg              <= ta_count_next;
         tb_data_reg               <= tb_data_next;
         tb_count_reg              <= tb_count_next;
         pend_reg                  <= pend_next;
         pre_reg                   <= pre_next;
         cap_sync_reg              <= cap_sync_next;
         ext_sync_reg              <= ext_sync_next;
         timer_a_output_pin_out    <= ta_out_next;
         timer_a_output_pin_oe     <= port3_high_reg[timer_a_pkg::P3H_OUT_BIT];
         timer_a_overflow_irq      <= ovf_irq_next;
         timer_a_match_capture_irq <= mc_irq_next;
         timer_b_irq               <= tb_irq_next;
         timer_b_carrier_out       <= tb_out_next;
         reg_rdata                 <= rdata_next;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   capture_latch_a: assert property (capture_evt |=> ta_data_reg == $past(ta_count_reg))
      else $error("capture did not latch the count");
   edge_select_a: assert property ((ta_mode == timer_a_pkg::MODE_CAPTURE)
      && !port3_high_reg[timer_a_pkg::P3H_OUT_BIT] && cap_fall
      && !cap_config_reg[timer_a_pkg::CAP_RISING_BIT] |-> capture_evt)
      else $error("falling edge missed");
   pin_output_a: assert property (port3_high_reg[timer_a_pkg::P3H_OUT_BIT]
      |-> !capture_evt ##1 timer_a_output_pin_oe)
      else $error("output pin function wrong");
   overflow_pend_a: assert property (ta_ovf |=> pend_reg[timer_a_pkg::PND_OVF_BIT])
      else $error("overflow not pending");
   capture_pend_a: assert property (capture_evt |=> pend_reg[timer_a_pkg::PND_MC_BIT]
      ##1 (timer_a_match_capture_irq == ta_control_reg[timer_a_pkg::TA_MC_IE_BIT]
           || $changed(ta_control_reg)))
      else $error("capture pending or irq wrong");
   reset_value_a: assert property ($past(sys_rst) |-> ta_control_reg == 8'h00)
      else $error("control not cleared by reset");
   count_clear_a: assert property (ta_clr_wr |=> ta_count_reg == 8'h00)
      else $error("counter not cleared");
   count_hold_a: assert property (!ta_control_reg[timer_a_pkg::TA_START_BIT] && !ta_clr_wr
      |=> $stable(ta_count_reg))
      else $error("stopped counter moved");
   irq_gate_a: assert property (timer_a_match_capture_irq
      |-> $past(ta_control_reg[timer_a_pkg::TA_MC_IE_BIT]))
      else $error("match irq while disabled");
   pend_clear_a: assert property (wr_hit(timer_a_pkg::ADDR_PENDING)
      && !reg_wdata[timer_a_pkg::PND_OVF_BIT] && !ta_ovf
      |=> !pend_reg[timer_a_pkg::PND_OVF_BIT])
      else $error("pending not cleared by zero write");
   interval_clr_a: assert property (ta_match && (ta_mode == timer_a_pkg::MODE_INTERVAL)
      && !ta_clr_wr |=> ta_count_reg == 8'h00 && $changed(timer_a_output_pin_out))
      else $error("interval match misbehaved");
   capture_runs_a: assert property (capture_evt && ta_tick && !ta_clr_wr
      |=> ta_count_reg == $past(ta_count_reg) + 8'h01)
      else $error("capture disturbed counting");

   capture_seen_c: cover property (capture_evt ##1 pend_reg[timer_a_pkg::PND_MC_BIT]);
   overflow_seen_c: cover property (ta_ovf);
   interval_seen_c: cover property (ta_match && (ta_mode == timer_a_pkg::MODE_INTERVAL));
   timer_b_seen_c: cover property (tb_match);
endmodule // timer_a_capture_control
`default_nettype wire

// File: src/timer_a_pkg.sv
`default_nettype none
package timer_a_pkg;
   localparam int          DATA_W          = 8;
   localparam int          PRE_W           = 10;
   // register map
   localparam logic [7:0]  ADDR_PORT3_HIGH = 8'hEC;
   localparam logic [7:0]  ADDR_TA_CONTROL = 8'hF3;
   localparam logic [7:0]  ADDR_TA_DATA    = 8'hF4;
   localparam logic [7:0]  ADDR_TA_COUNT   = 8'hF5;
   localparam logic [7:0]  ADDR_PENDING    = 8'hF6;
   localparam logic [7:0]  ADDR_TB_CONTROL = 8'hF7;
   localparam logic [7:0]  ADDR_TB_DATA    = 8'hF8;
   localparam logic [7:0]  ADDR_TB_COUNT   = 8'hF9;
   localparam logic [7:0]  ADDR_CAP_CONFIG = 8'hFA;
   localparam logic [7:0]  RESET_VALUE     = 8'h00;
   localparam logic [7:0]  COUNT_MAX       = 8'hFF;
   localparam logic [7:0]  COUNT_ZERO      = 8'h00;
   // timer a control fields
   localparam int          TA_MODE_LSB     = 6;
   localparam int          TA_CLK_LSB      = 4;
   localparam int          TA_CLR_BIT      = 3;
   localparam int          TA_OVF_IE_BIT   = 2;
   localparam int          TA_MC_IE_BIT    = 1;
   localparam int          TA_START_BIT    = 0;
   localparam logic [1:0]  MODE_INTERVAL   = 2'h0;
   localparam logic [1:0]  MODE_CAPTURE    = 2'h1;
   localparam logic [1:0]  MODE_PWM        = 2'h2;
   localparam logic [1:0]  CLK_DIV1024     = 2'h0;
   localparam logic [1:0]  CLK_DIV256      = 2'h1;
   localparam logic [1:0]  CLK_DIV64       = 2'h2;
   localparam logic [9:0]  MASK_DIV1024    = 10'h3FF;
   localparam logic [9:0]  MASK_DIV256     = 10'h0FF;
   localparam logic [9:0]  MASK_DIV64      = 10'h03F;
   // port 3 high control: bit 5 high turns the capture pin into an output
   localparam int          P3H_OUT_BIT     = 5;
   // pending bits
   localparam int          PND_MC_BIT      = 0;
   localparam int          PND_OVF_BIT     = 1;
   localparam int          PND_TB_BIT      = 2;
   localparam int          PND_W           = 3;
   // timer b control fields, then the capture config edge bit
   localparam int          TB_START_BIT    = 0;
   localparam int          TB_IE_BIT       = 1;
   localparam int          TB_CLK_LSB      = 2;
   localparam int          TB_CLR_BIT      = 4;
   localparam int          CAP_RISING_BIT  = 0;
endpackage
`default_nettype wire

// File: test/capture_source.sv
`timescale 1ns/10ps
`default_nettype none
// external signal source at the capture pin; the level follows the request after LAG cycles
module capture_source #(
   parameter int LAG = 3
) (
   input  wire logic clk,
   input  wire logic level_req,
   output logic      capture_input_pin
);
   logic [LAG-1:0] delay_reg;

   // a real source is never aligned to our clock, so the pin lags the request
   always_ff @(posedge clk)
   begin
      delay_reg <= {delay_reg[LAG-2:0], level_req};
   end

   assign capture_input_pin = delay_reg[LAG-1];
endmodule // capture_source
`default_nettype wire

// File: test/tb_timer_a_capture_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_timer_a_capture_control;
   logic       clk;
   logic       sys_rst;
   logic [7:0] reg_addr;
   logic       reg_wr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic       level_req;
   logic       cap_pin;
   logic       ext_clk;
   logic       out_pin;
   logic       out_oe;
   logic       ovf_irq;
   logic       mc_irq;
   logic       tb_irq;
   logic       tb_carrier;
   logic [7:0] rd_val;
   logic       out_before;
   int         fails;
   int         checks;
   int         cycles;

   timer_a_capture_control u_dut (
      .clk                        (clk),
      .sys_rst                    (sys_rst),
      .reg_addr                   (reg_addr),
      .reg_wr                     (reg_wr),
      .reg_wdata                  (reg_wdata),
      .reg_rdata                  (reg_rdata),
      .capture_input_pin          (cap_pin),
      .timer_a_external_clock_pin (ext_clk),
      .timer_a_output_pin_out     (out_pin),
      .timer_a_output_pin_oe      (out_oe),
      .timer_a_overflow_irq       (ovf_irq),
      .timer_a_match_capture_irq  (mc_irq),
      .timer_b_irq                (tb_irq),
      .timer_b_carrier_out        (tb_carrier)
   );

   capture_source #(.LAG(3)) u_src (
      .clk               (clk),
      .level_req         (level_req),
      .capture_input_pin (cap_pin)
   );

   initial clk = 1'b0;
   always #5 clk = ~clk;

   task automatic finish_test();
      if (fails == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ceiling well above the ~1400 cycles the sequence needs
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fails = fails + 1;
         finish_test();
      end
   end

   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      checks = checks + 1;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         fails = fails + 1;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   // read data is registered: one edge to present the address, one to register
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wr   <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      #1;
      d = reg_rdata;
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      rd(a, rd_val);
      chk(what, rd_val, exp);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // external count clock: two cycles high, two low, per tick
   task automatic ticks(input int n);
      repeat (n)
      begin
         @(posedge clk);
         ext_clk <= 1'b1;
         repeat (2) @(posedge clk);
         ext_clk <= 1'b0;
         @(posedge clk);
      end
      idle(6);
   endtask

   task automatic pin(input logic lvl);
      @(posedge clk);
      level_req <= lvl;
      idle(10);
   endtask

   initial
   begin
      fails = 0;
      checks = 0;
      cycles = 0;
      sys_rst = 1'b1;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      level_req = 1'b1;
      ext_clk = 1'b0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rd_chk("control reset", timer_a_pkg::ADDR_TA_CONTROL, 8'h00);
      chk("irq after reset", {6'h00, ovf_irq, mc_irq}, 8'h00);
      rd_chk("unmapped read", 8'h10, 8'h00);
      // capture mode, external clock, clear, both irq enables, start
      wr(timer_a_pkg::ADDR_TA_CONTROL, 8'h7F);
      rd_chk("control readback", timer_a_pkg::ADDR_TA_CONTROL, 8'h77);
      ticks(5);
      rd_chk("count running", timer_a_pkg::ADDR_TA_COUNT, 8'h05);
      pin(1'b0);
      rd_chk("falling capture", timer_a_pkg::ADDR_TA_DATA, 8'h05);
      rd_chk("capture pending", timer_a_pkg::ADDR_PENDING, 8'h01);
      chk("mc irq on", {7'h00, mc_irq}, 8'h01);
      rd_chk("count kept", timer_a_pkg::ADDR_TA_COUNT, 8'h05);
      wr(timer_a_pkg::ADDR_PENDING, 8'hFE);
      idle(3);
      chk("mc irq cleared", {7'h00, mc_irq}, 8'h00);
      pin(1'b1);
      rd_chk("rising ignored", timer_a_pkg::ADDR_PENDING, 8'h00);
      ticks(3);
      wr(timer_a_pkg::ADDR_CAP_CONFIG, 8'h01);
      pin(1'b0);
      pin(1'b1);
      rd_chk("rising capture", timer_a_pkg::ADDR_TA_DATA, 8'h08);
      // clear strobe with match/capture irq enable now off
      wr(timer_a_pkg::ADDR_TA_CONTROL, 8'h7D);
      rd_chk("pending by clear", timer_a_pkg::ADDR_PENDING, 8'h00);
      rd_chk("count cleared", timer_a_pkg::ADDR_TA_COUNT, 8'h00);
      wr(timer_a_pkg::ADDR_PORT3_HIGH, 8'h20);
      wr(timer_a_pkg::ADDR_TA_DATA, 8'hAA);
      idle(3);
      chk("pin as output", {7'h00, out_oe}, 8'h01);
      pin(1'b0);
      pin(1'b1);
      rd_chk("no capture on output", timer_a_pkg::ADDR_TA_DATA, 8'hAA);
      wr(timer_a_pkg::ADDR_PORT3_HIGH, 8'h10);
      pin(1'b0);
      pin(1'b1);
      chk("pin as input", {7'h00, out_oe}, 8'h00);
      rd_chk("capture on input", timer_a_pkg::ADDR_TA_DATA, 8'h00);
      rd_chk("pending masked", timer_a_pkg::ADDR_PENDING, 8'h01);
      chk("mc irq masked", {7'h00, mc_irq}, 8'h00);
      wr(timer_a_pkg::ADDR_PENDING, 8'h00);
      ticks(256);
      rd_chk("overflow pending", timer_a_pkg::ADDR_PENDING, 8'h02);
      chk("ovf irq on", {7'h00, ovf_irq}, 8'h01);
      rd_chk("wrapped count", timer_a_pkg::ADDR_TA_COUNT, 8'h00);
      idle(20);
      rd_chk("overflow held", timer_a_pkg::ADDR_PENDING, 8'h02);
      wr(timer_a_pkg::ADDR_PENDING, 8'hFD);
      idle(3);
      chk("ovf irq cleared", {7'h00, ovf_irq}, 8'h00);
      // interval mode: match at 5 clears count and toggles output
      wr(timer_a_pkg::ADDR_TA_DATA, 8'h05);
      wr(timer_a_pkg::ADDR_TA_CONTROL, 8'h3B);
      idle(3);
      out_before = out_pin;
      // count sits at the data value for one tick; the next tick matches
      ticks(6);
      rd_chk("interval clear", timer_a_pkg::ADDR_TA_COUNT, 8'h00);
      chk("interval toggle", {7'h00, out_pin}, {7'h00, ~out_before});
      rd_chk("match pending", timer_a_pkg::ADDR_PENDING, 8'h01);
      // pwm mode: output high while data above count
      wr(timer_a_pkg::ADDR_TA_DATA, 8'h03);
      wr(timer_a_pkg::ADDR_TA_CONTROL, 8'hB9);
      idle(4);
      chk("pwm high", {7'h00, out_pin}, 8'h01);
      // fourth tick is the match tick: it must not clear in pwm
      ticks(4);
      chk("pwm low", {7'h00, out_pin}, 8'h00);
      rd_chk("pwm no clear", timer_a_pkg::ADDR_TA_COUNT, 8'h04);
      wr(timer_a_pkg::ADDR_TA_CONTROL, 8'hB0);
      ticks(2);
      rd_chk("stopped count", timer_a_pkg::ADDR_TA_COUNT, 8'h04);
      // second counter: match at 2 on external clock, irq enabled
      wr(timer_a_pkg::ADDR_PENDING, 8'h00);
      wr(timer_a_pkg::ADDR_TB_DATA, 8'h02);
      wr(timer_a_pkg::ADDR_TB_CONTROL, 8'h0F);
      ticks(3);
      rd_chk("tb pending", timer_a_pkg::ADDR_PENDING, 8'h04);
      chk("tb irq on", {7'h00, tb_irq}, 8'h01);
      chk("tb carrier", {7'h00, tb_carrier}, 8'h01);
      rd_chk("tb count cleared", timer_a_pkg::ADDR_TB_COUNT, 8'h00);
      finish_test();
   end
endmodule // tb_timer_a_capture_control
`default_nettype wire
